// ### psl_pkg.sv
// shared constants and a helper function for the position sensor link process data block
package psl_pkg;

    // ---------------------------------------------------------------
    // process data image layout
    // ---------------------------------------------------------------
    localparam int PD_BYTES     = 4;
    localparam int PD_W         = 32;
    localparam int PD_POS_LSB   = 16;
    localparam int PD_SCALE_LSB = 8;
    localparam int PD_BITS_LSB  = 0;

    // ---------------------------------------------------------------
    // system command values
    // ---------------------------------------------------------------
    localparam logic [7:0] CMD_DEVICE_RESET  = 8'h80;
    localparam logic [7:0] CMD_APP_RESET     = 8'h81;
    localparam logic [7:0] CMD_FACTORY_RESET = 8'h82;
    localparam logic [7:0] CMD_TRAINED_RESET = 8'hC0;
    localparam logic [7:0] CMD_DIAG_RESET    = 8'hE4;
    localparam logic [7:0] CMD_ALERT_RESET   = 8'hE5;

    // ---------------------------------------------------------------
    // parameter selectors on the link (4-bit)
    // ---------------------------------------------------------------
    localparam logic [3:0] PAR_ANA_START  = 4'h0;
    localparam logic [3:0] PAR_ANA_END    = 4'h1;
    localparam logic [3:0] PAR_NOISE_LIM  = 4'h2;
    localparam logic [3:0] PAR_PD_MODE    = 4'h3;
    localparam logic [3:0] PAR_RANGE_LO   = 4'h4;
    localparam logic [3:0] PAR_RANGE_HI   = 4'h5;
    localparam logic [3:0] PAR_CYCLES     = 4'h6;
    localparam logic [3:0] PAR_TRAVEL_SUM = 4'h7;
    localparam logic [3:0] PAR_HOURS_SNC  = 4'h8;
    localparam logic [3:0] PAR_HOURS_TOT  = 4'h9;
    localparam logic [3:0] PAR_PWR_SNC    = 4'hA;
    localparam logic [3:0] PAR_PWR_TOT    = 4'hB;
    localparam logic [3:0] PAR_ALERTS     = 4'hC;
    localparam logic [3:0] PAR_STROKE     = 4'hD;
    localparam logic [3:0] PAR_CYCLE_TIME = 4'hE;
    localparam logic [3:0] PAR_STATUS     = 4'hF;

    // ---------------------------------------------------------------
    // defaults (positions in 10 um digits)
    // ---------------------------------------------------------------
    localparam logic signed [15:0] ANA_START_DEF = 16'shF63C;  // -2500
    localparam logic signed [15:0] ANA_END_DEF   = 16'sh09C4;  // +2500
    localparam logic signed [15:0] RANGE_LO_DEF  = 16'shF63C;  // -25 mm
    localparam logic signed [15:0] RANGE_HI_DEF  = 16'sh09C4;  // +25 mm
    localparam logic [15:0]        NOISE_DEF     = 16'h0064;
    localparam logic signed [7:0]  SCALE_VAL     = 8'shFE;     // 10^-2 mm per digit
    localparam logic [11:0]        ANA_FULL      = 12'hFFF;    // code for 10 V
    localparam logic [11:0]        ANA_ZERO      = 12'h000;
    localparam logic [3:0]         LEARN_FULL    = 4'h5;
    localparam logic [3:0]         LEARN_FAST    = 4'h2;

    // ---------------------------------------------------------------
    // host-side user register addresses
    // ---------------------------------------------------------------
    localparam logic [3:0] HA_CMD     = 4'h0;
    localparam logic [3:0] HA_LINK    = 4'h1;
    localparam logic [3:0] HA_PD_LO   = 4'h2;
    localparam logic [3:0] HA_PD_HI   = 4'h3;
    localparam logic [3:0] HA_PAR_WR  = 4'h4;
    localparam logic [3:0] HA_PAR_REQ = 4'h5;
    localparam logic [3:0] HA_PAR_DAT = 4'h6;

    function automatic logic [15:0] pslAbsDiff(input logic signed [15:0] a,
                                               input logic signed [15:0] b);
        logic signed [16:0] d;
        d = 17'(a) - 17'(b);
        return d[16] ? 16'(-d) : d[15:0];
    endfunction

endpackage

// ### psl_link_if.sv
// link between the link master and the sensor device
`timescale 1ns/1ps
interface psl_link_if;
    logic [31:0] pdData;
    logic        linkActive;
    logic        cmdValid;
    logic [7:0]  cmdCode;
    logic        parWr;
    logic        parRd;
    logic [3:0]  parSel;
    logic [15:0] parWrData;
    logic [15:0] parRdData;
    logic        parRdValid;

    modport device (output pdData, output parRdData, output parRdValid,
                    input linkActive, input cmdValid, input cmdCode,
                    input parWr, input parRd, input parSel, input parWrData);
    modport master (input pdData, input parRdData, input parRdValid,
                    output linkActive, output cmdValid, output cmdCode,
                    output parWr, output parRd, output parSel, output parWrData);
endinterface

// ### psl_analog_scale.sv
// analog output scaler: position to 0..10 V code
`timescale 1ns/1ps
module psl_analog_scale import psl_pkg::*; (
    input  wire logic               clk,
    input  wire logic               arst_n,
    input  wire logic               linkActive,
    input  wire logic signed [15:0] pos,
    input  wire logic signed [15:0] startPt,
    input  wire logic signed [15:0] endPt,
    output logic [11:0]             code,
    output logic                    enable
);
    typedef struct packed {
        logic [11:0] code;
        logic        en;
    } psl_scale_t;

    psl_scale_t st_reg, st_next;
    logic signed [31:0] num;
    logic signed [31:0] span;
    logic signed [31:0] quo;

    always_comb begin
        st_next = st_reg;
        num  = (32'(pos) - 32'(startPt)) * 32'(ANA_FULL);
        span = 32'(endPt) - 32'(startPt);
        quo  = (span > 0) ? num / span : 32'sd0;
        if (linkActive) begin
            st_next.code = ANA_ZERO;
            st_next.en   = 1'b0;
        end else begin
            st_next.en = 1'b1;
            if (span <= 0 || pos <= startPt) begin
                st_next.code = ANA_ZERO;
            end else if (pos >= endPt) begin
                st_next.code = ANA_FULL;
            end else begin
                st_next.code = quo[11:0];
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign code   = st_reg.code;
    assign enable = st_reg.en;
endmodule // psl_analog_scale

// ### psl_device.sv
// sensor device end: process data, diagnostics, commands, analog output
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module psl_device import psl_pkg::*; (
    input  wire logic               clk,
    input  wire logic               arst_n,
    psl_link_if.device              link,
    input  wire logic signed [15:0] posIn,
    input  wire logic               posValid,
    input  wire logic               strokeDone,
    input  wire logic [15:0]        fieldIn,
    input  wire logic [7:0]         switchIn,
    input  wire logic [7:0]         alertIn,
    input  wire logic               msTick,
    input  wire logic               hourTick,
    output logic [11:0]             analogCode,
    output logic                    analogEnable,
    output logic                    learned
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic               pdMode;
        logic signed [15:0] anaStart;
        logic signed [15:0] anaEnd;
        logic [15:0]        noiseLim;
        logic signed [15:0] lastPos;
        logic [15:0]        travelCur;
        logic [15:0]        cycleTime;
        logic [15:0]        cycleTimer;
        logic [15:0]        curField;
        logic [15:0]        peakField;
        logic [31:0]        travelSum;
        logic [31:0]        cycleCount;
        logic [31:0]        hoursTot;
        logic [31:0]        hoursSnc;
        logic [15:0]        pwrTot;
        logic [15:0]        pwrSnc;
        logic [7:0]         alerts;
        logic signed [15:0] minSeen;
        logic signed [15:0] maxSeen;
        logic [3:0]         strokes;
        logic [3:0]         need;
        logic               booted;
        logic               learned;
        logic [31:0]        pd;
        logic [15:0]        rdData;
        logic               rdValid;
    } psl_dev_t;

    psl_dev_t st_reg, st_next;
    logic signed [15:0] rangeLo;
    logic signed [15:0] rangeHi;
    logic signed [16:0] loWide;
    logic signed [16:0] hiWide;
    logic               isCmd;

    // ---------------------------------------------------------------
    // application range
    // ---------------------------------------------------------------
    always_comb begin
        loWide = 17'(st_reg.minSeen) - 17'(st_reg.noiseLim);
        hiWide = 17'(st_reg.maxSeen) + 17'(st_reg.noiseLim);
        if (st_reg.strokes == '0) begin
            rangeLo = RANGE_LO_DEF;
            rangeHi = RANGE_HI_DEF;
        end else begin
            rangeLo = (loWide < 17'(RANGE_LO_DEF)) ? RANGE_LO_DEF : loWide[15:0];
            rangeHi = (hiWide > 17'(RANGE_HI_DEF)) ? RANGE_HI_DEF : hiWide[15:0];
        end
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.rdValid = 1'b0;
        isCmd = link.cmdValid;

        // power cycle is counted once after reset release
        if (!st_reg.booted) begin
            st_next.booted = 1'b1;
            st_next.pwrTot = st_reg.pwrTot + 16'h0001;
            st_next.pwrSnc = st_reg.pwrSnc + 16'h0001;
        end
        if (hourTick) begin
            st_next.hoursTot = st_reg.hoursTot + 32'h0000_0001;
            st_next.hoursSnc = st_reg.hoursSnc + 32'h0000_0001;
        end
        if (msTick) begin
            st_next.cycleTimer = st_reg.cycleTimer + 16'h0001;
        end
        st_next.curField = fieldIn;
        if (fieldIn > st_reg.peakField) begin
            st_next.peakField = fieldIn;
        end
        if (posValid) begin
            st_next.lastPos   = posIn;
            st_next.travelCur = st_reg.travelCur + pslAbsDiff(posIn, st_reg.lastPos);
            if (posIn < st_reg.minSeen) begin
                st_next.minSeen = posIn;
            end
            if (posIn > st_reg.maxSeen) begin
                st_next.maxSeen = posIn;
            end
        end
        if (strokeDone) begin
            st_next.travelSum  = st_reg.travelSum + 32'(st_next.travelCur);
            st_next.cycleCount = st_reg.cycleCount + 32'h0000_0001;
            st_next.cycleTime  = st_reg.cycleTimer;
            st_next.cycleTimer = '0;
            st_next.travelCur  = '0;
            if (st_reg.strokes != 4'hF) begin
                st_next.strokes = st_reg.strokes + 4'h1;
            end
        end
        st_next.learned = (st_reg.strokes >= st_reg.need);

        // alerts: a new event wins over a clear in the same cycle
        st_next.alerts = st_reg.alerts | alertIn;

        if (link.parWr) begin
            unique case (link.parSel)
                PAR_ANA_START: st_next.anaStart = link.parWrData;
                PAR_ANA_END:   st_next.anaEnd   = link.parWrData;
                PAR_NOISE_LIM: st_next.noiseLim = link.parWrData;
                PAR_PD_MODE:   st_next.pdMode   = link.parWrData[0];
                default: ;
            endcase
        end

        if (isCmd) begin
            unique case (link.cmdCode)
                CMD_DEVICE_RESET: begin
                    st_next.travelCur  = '0;
                    st_next.cycleTime  = '0;
                    st_next.cycleTimer = '0;
                    st_next.curField   = '0;
                    st_next.peakField  = '0;
                end
                CMD_FACTORY_RESET, CMD_APP_RESET: begin
                    st_next.pdMode   = 1'b0;
                    st_next.anaStart = ANA_START_DEF;
                    st_next.anaEnd   = ANA_END_DEF;
                    st_next.noiseLim = NOISE_DEF;
                    st_next.minSeen  = RANGE_HI_DEF;
                    st_next.maxSeen  = RANGE_LO_DEF;
                    st_next.strokes  = '0;
                    st_next.need     = LEARN_FAST;
                end
                CMD_TRAINED_RESET: begin
                    st_next.minSeen = RANGE_HI_DEF;
                    st_next.maxSeen = RANGE_LO_DEF;
                    st_next.strokes = '0;
                    st_next.need    = LEARN_FAST;
                end
                CMD_DIAG_RESET: begin
                    st_next.hoursSnc   = hourTick ? 32'h0000_0001 : '0;
                    st_next.pwrSnc     = '0;
                    st_next.cycleCount = strokeDone ? 32'h0000_0001 : '0;
                    st_next.travelSum  = strokeDone ? 32'(st_next.travelCur) : '0;
                end
                CMD_ALERT_RESET: st_next.alerts = alertIn;
                default: ;
            endcase
        end

        if (link.parRd) begin
            st_next.rdValid = 1'b1;
            unique case (link.parSel)
                PAR_ANA_START:  st_next.rdData = st_reg.anaStart;
                PAR_ANA_END:    st_next.rdData = st_reg.anaEnd;
                PAR_NOISE_LIM:  st_next.rdData = st_reg.noiseLim;
                PAR_PD_MODE:    st_next.rdData = {15'h0000, st_reg.pdMode};
                PAR_RANGE_LO:   st_next.rdData = rangeLo;
                PAR_RANGE_HI:   st_next.rdData = rangeHi;
                PAR_CYCLES:     st_next.rdData = st_reg.cycleCount[15:0];
                PAR_TRAVEL_SUM: st_next.rdData = st_reg.travelSum[15:0];
                PAR_HOURS_SNC:  st_next.rdData = st_reg.hoursSnc[15:0];
                PAR_HOURS_TOT:  st_next.rdData = st_reg.hoursTot[15:0];
                PAR_PWR_SNC:    st_next.rdData = st_reg.pwrSnc;
                PAR_PWR_TOT:    st_next.rdData = st_reg.pwrTot;
                PAR_ALERTS:     st_next.rdData = {8'h00, st_reg.alerts};
                PAR_STROKE:     st_next.rdData = st_reg.travelCur;
                PAR_CYCLE_TIME: st_next.rdData = st_reg.cycleTime;
                PAR_STATUS:     st_next.rdData = {11'h000, st_reg.learned, st_reg.strokes};
            endcase
        end

        st_next.pd = '0;
        st_next.pd[PD_POS_LSB +: 16]  = st_reg.lastPos;
        st_next.pd[PD_SCALE_LSB +: 8] = SCALE_VAL;
        st_next.pd[PD_BITS_LSB +: 8]  = st_reg.pdMode ? st_reg.alerts : switchIn;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg          <= '0;
            st_reg.anaStart <= ANA_START_DEF;
            st_reg.anaEnd   <= ANA_END_DEF;
            st_reg.noiseLim <= NOISE_DEF;
            st_reg.minSeen  <= RANGE_HI_DEF;
            st_reg.maxSeen  <= RANGE_LO_DEF;
            st_reg.need     <= LEARN_FULL;
        end else begin
            st_reg <= st_next;
        end
    end

    // ---------------------------------------------------------------
    // analog output
    // ---------------------------------------------------------------
    psl_analog_scale u_scale (
        .clk        (clk),
        .arst_n     (arst_n),
        .linkActive (link.linkActive),
        .pos        (st_reg.lastPos),
        .startPt    (st_reg.anaStart),
        .endPt      (st_reg.anaEnd),
        .code       (analogCode),
        .enable     (analogEnable)
    );

    assign link.pdData     = st_reg.pd;
    assign link.parRdData  = st_reg.rdData;
    assign link.parRdValid = st_reg.rdValid;
    assign learned         = st_reg.learned;
endmodule // psl_device

// ### psl_master.sv
// link master end: issues commands and parameter access, captures process data
`timescale 1ns/1ps
module psl_master import psl_pkg::*; (
    input  wire logic        clk,
    input  wire logic        arst_n,
    psl_link_if.master       link,
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wrData,
    input  wire logic        wrStb,
    input  wire logic        rdStb,
    output logic [31:0]      rdData
);
    typedef struct packed {
        logic        linkActive;
        logic        cmdValid;
        logic [7:0]  cmdCode;
        logic        parWr;
        logic        parRd;
        logic [3:0]  parSel;
        logic [15:0] parWrData;
        logic [15:0] parData;
        logic        parDone;
        logic [31:0] pd;
        logic [31:0] rdData;
    } psl_mst_t;

    psl_mst_t st_reg, st_next;

    always_comb begin
        st_next = st_reg;
        st_next.cmdValid = 1'b0;
        st_next.parWr    = 1'b0;
        st_next.parRd    = 1'b0;
        st_next.rdData   = '0;
        st_next.pd       = link.pdData;
        if (link.parRdValid) begin
            st_next.parData = link.parRdData;
            st_next.parDone = 1'b1;
        end
        if (wrStb) begin
            unique case (addr)
                HA_CMD: begin
                    st_next.cmdValid = 1'b1;
                    st_next.cmdCode  = wrData[7:0];
                end
                HA_LINK: st_next.linkActive = wrData[0];
                HA_PAR_WR: begin
                    st_next.parWr     = 1'b1;
                    st_next.parSel    = wrData[19:16];
                    st_next.parWrData = wrData[15:0];
                end
                HA_PAR_REQ: begin
                    st_next.parRd   = 1'b1;
                    st_next.parSel  = wrData[19:16];
                    st_next.parDone = 1'b0;
                end
                default: ;
            endcase
        end
        if (rdStb) begin
            unique case (addr)
                HA_LINK:    st_next.rdData = {31'h0000_0000, st_reg.linkActive};
                HA_PD_LO:   st_next.rdData = {16'h0000, st_reg.pd[15:0]};
                HA_PD_HI:   st_next.rdData = {16'h0000, st_reg.pd[31:16]};
                HA_PAR_DAT: st_next.rdData = {15'h0000, st_reg.parDone, st_reg.parData};
                default:    st_next.rdData = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg            <= '0;
            st_reg.linkActive <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign link.linkActive = st_reg.linkActive;
    assign link.cmdValid   = st_reg.cmdValid;
    assign link.cmdCode    = st_reg.cmdCode;
    assign link.parWr      = st_reg.parWr;
    assign link.parRd      = st_reg.parRd;
    assign link.parSel     = st_reg.parSel;
    assign link.parWrData  = st_reg.parWrData;
    assign rdData          = st_reg.rdData;
endmodule // psl_master

// ### psl_link_chk.sv
// assertions on the link between the master end and the sensor end
`timescale 1ns/1ps
module psl_link_chk import psl_pkg::*; (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic [31:0] pdData,
    input wire logic        linkActive,
    input wire logic        cmdValid,
    input wire logic [7:0]  cmdCode,
    input wire logic        parWr,
    input wire logic        parRd,
    input wire logic [3:0]  parSel,
    input wire logic [15:0] parWrData,
    input wire logic [15:0] parRdData,
    input wire logic        parRdValid
);
    // ---------------------------------------------------------------
    // link properties
    // ---------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    scale_fixed_a: assert property ($past(arst_n) |-> pdData[15:8] == SCALE_VAL)
        else $error("scale byte wrong");
    rd_answer_a: assert property (parRd |=> parRdValid)
        else $error("read answer missing");
    rd_cause_a: assert property (parRdValid |-> $past(parRd))
        else $error("read answer without request");
    one_req_a: assert property ($onehot0({cmdValid, parWr, parRd}))
        else $error("two link requests at once");
    link_reset_a: assert property (!$past(arst_n) |-> linkActive)
        else $error("link not active after reset");
    sel_hold_a: assert property (!$stable(parSel) |-> parWr || parRd)
        else $error("selector moved without request");
    code_hold_a: assert property (!$stable(cmdCode) |-> cmdValid)
        else $error("command code moved without strobe");
    // the bench holds the switch inputs steady, so the low half must not move
    bad_cmd_a: assert property (cmdValid && !(cmdCode inside {8'h80, 8'h81, 8'h82, 8'hC0,
        8'hE4, 8'hE5}) |=> pdData[15:0] == $past(pdData[15:0]))
        else $error("unknown command changed image");
    cover property (cmdValid && cmdCode == CMD_ALERT_RESET);
    cover property (parRdValid && parRdData != 16'h0000);
    cover property (parWr && parSel == PAR_ANA_END && parWrData != 16'h0000);
endmodule // psl_link_chk

// ### tb.sv
// self-checking bench joining the master end and the sensor end
`timescale 1ns/1ps
module tb import psl_pkg::*; ;
    logic               clk = 1'b0;
    logic               arst_n = 1'b0;
    logic [3:0]         addr = 4'h0;
    logic [31:0]        wrData = 32'h0000_0000;
    logic               wrStb = 1'b0;
    logic               rdStb = 1'b0;
    logic [31:0]        rdData;
    logic signed [15:0] posIn = 16'sh0000;
    logic               posValid = 1'b0;
    logic               strokeDone = 1'b0;
    logic               hourTick = 1'b0;
    logic               msTick = 1'b0;
    logic [7:0]         alertIn = 8'h00;
    logic [11:0]        analogCode;
    logic               analogEnable;
    logic               learned;
    int                 fails = 0;
    int                 totalChecks = 0;

    always #2.5 clk = ~clk;
    psl_link_if lnk();
    psl_master i_psl_master(.clk, .arst_n, .link(lnk.master), .addr, .wrData, .wrStb, .rdStb,
        .rdData);
    psl_device i_psl_device(.clk, .arst_n, .link(lnk.device), .posIn, .posValid, .strokeDone,
        .fieldIn(16'h0040), .switchIn(8'h5A), .alertIn, .msTick, .hourTick, .analogCode,
        .analogEnable, .learned);
    psl_link_chk i_psl_link_chk(.clk, .arst_n, .pdData(lnk.pdData), .linkActive(lnk.linkActive),
        .cmdValid(lnk.cmdValid), .cmdCode(lnk.cmdCode), .parWr(lnk.parWr), .parRd(lnk.parRd),
        .parSel(lnk.parSel), .parWrData(lnk.parWrData), .parRdData(lnk.parRdData),
        .parRdValid(lnk.parRdValid));

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        totalChecks++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr   <= a;
        wrData <= d;
        wrStb  <= 1'b1;
        @(posedge clk);
        wrStb  <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        rdStb <= 1'b1;
        @(posedge clk);
        rdStb <= 1'b0;
        #1 d = rdData;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [15:0] e, input string n);
        logic [31:0] d;
        rd(a, d);
        chk(n, e, d[15:0]);
    endtask
    // command effects land one cycle after the link pulse
    task automatic cmd(input logic [7:0] c);
        wr(HA_CMD, {24'h00_0000, c});
        repeat (2) @(posedge clk);
    endtask
    task automatic pset(input logic [3:0] s, input logic [15:0] v);
        wr(HA_PAR_WR, {12'h000, s, v});
    endtask
    task automatic pget(input logic [3:0] s, input logic [15:0] e, input string n);
        logic [31:0] d;
        int i;
        wr(HA_PAR_REQ, {12'h000, s, 16'h0000});
        repeat (3) @(posedge clk);
        d = 32'h0000_0000;
        for (i = 0; i < 20 && d[16] !== 1'b1; i++)
            rd(HA_PAR_DAT, d);
        if (d[16] !== 1'b1) begin
            fails++;
            finish_test();
        end else begin
            chk(n, e, d[15:0]);
        end
    endtask
    task automatic stroke(input logic signed [15:0] p);
        @(posedge clk);
        posIn      <= p;
        posValid   <= 1'b1;
        strokeDone <= 1'b1;
        hourTick   <= 1'b1;
        @(posedge clk);
        posValid   <= 1'b0;
        strokeDone <= 1'b0;
        hourTick   <= 1'b0;
        // one ms tick between strokes gives a known cycle time
        msTick     <= 1'b1;
        @(posedge clk);
        msTick     <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic ana(input int p, input int s, input int e, input bit on);
        int x;
        x = (p - s) * 4095 / (e - s);
        x = (x < 0 || !on) ? 0 : (x > 4095 ? 4095 : x);
        @(posedge clk);
        posIn    <= 16'(p);
        posValid <= 1'b1;
        @(posedge clk);
        posValid <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk("analog", 16'(x), {4'h0, analogCode});
    endtask

    // ---------------------------------------------------------------
    // sequence
    // ---------------------------------------------------------------
    initial begin
        int p[6] = '{3000, 2500, 0, -2500, -3000, -1234};
        int q[3] = '{-10, 250, 1000};
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        rchk(HA_LINK, 16'h0001, "link");
        rchk(HA_PD_LO, 16'hFE5A, "image low");
        pget(PAR_RANGE_LO, 16'hF63C, "range low");
        pget(PAR_RANGE_HI, 16'h09C4, "range high");
        ana(2500, -2500, 2500, 0);
        chk("analog on", 16'h0000, {15'h0, analogEnable});
        $display("test defaults done");
        wr(HA_LINK, 32'h0000_0000);
        foreach (p[i]) ana(p[i], -2500, 2500, 1);
        rchk(HA_PD_HI, 16'hFB2E, "position");
        pset(PAR_ANA_START, 16'h0000);
        pset(PAR_ANA_END, 16'h03E8);
        foreach (q[i]) ana(q[i], 0, 1000, 1);
        $display("test analog done");
        repeat (4) stroke(16'sd2000);
        chk("early", 16'h0000, {15'h0, learned});
        stroke(-16'sd2000);
        chk("learned", 16'h0001, {15'h0, learned});
        ana(-1000, 0, 1000, 1);
        pget(PAR_STROKE, 16'h03E8, "stroke live");
        pget(PAR_CYCLE_TIME, 16'h0001, "cycle time");
        cmd(8'h7F);
        pget(PAR_CYCLES, 16'h0005, "cycles");
        cmd(CMD_DEVICE_RESET);
        pget(PAR_STROKE, 16'h0000, "stroke");
        pget(PAR_CYCLE_TIME, 16'h0000, "time cleared");
        pget(PAR_CYCLES, 16'h0005, "cycles kept");
        pget(PAR_ANA_END, 16'h03E8, "end kept");
        cmd(CMD_FACTORY_RESET);
        pget(PAR_ANA_END, 16'h09C4, "end default");
        pget(PAR_HOURS_TOT, 16'h0005, "hours kept");
        chk("relearn", 16'h0000, {15'h0, learned});
        repeat (2) stroke(16'sd1000);
        chk("fast learn", 16'h0001, {15'h0, learned});
        pget(PAR_RANGE_LO, 16'h0384, "range learnt");
        pset(PAR_NOISE_LIM, 16'h00C8);
        pget(PAR_RANGE_HI, 16'h04B0, "range wider");
        cmd(CMD_DIAG_RESET);
        pget(PAR_HOURS_SNC, 16'h0000, "hours since");
        pget(PAR_HOURS_TOT, 16'h0007, "hours total");
        pget(PAR_CYCLES, 16'h0000, "cycles cleared");
        pget(PAR_TRAVEL_SUM, 16'h0000, "travel");
        pget(PAR_PWR_SNC, 16'h0000, "power since");
        $display("test commands done");
        pset(PAR_PD_MODE, 16'h0001);
        @(posedge clk);
        alertIn <= 8'h21;
        @(posedge clk);
        alertIn <= 8'h00;
        // alert bit needs three register stages (alerts, device image, master copy) to reach the master copy
        @(posedge clk);
        rchk(HA_PD_LO, 16'hFE21, "alert bits");
        cmd(CMD_ALERT_RESET);
        rchk(HA_PD_LO, 16'hFE00, "alerts cleared");
        $display("test alerts done");
        finish_test();
    end
endmodule // tb
